// ---- logic/cerr_pkg.sv ----
// Constants, register map and types for the CAN error status and interrupt enable block
// Function
// - Last error code survives any change into initialization mode untouched.
// - Software write to last error code acts only when low byte written is zero.
// - Three-bit code: 0 none, 1 stuff, 2 form, 3 ack, 6 CRC, 7 undefined.
// - Code 4 when sent recessive outside arbitration but bus shows dominant.
// - Code 5 when sent dominant but bus shows recessive.
// - Bus-off flag high while transmit count is 256 or more, else low.
// - Transmit level field: 00 below 96, 01 for 96-127, 11 at 128 up.
// - Receive level field: 00 below 96, 01 for 96-127, 11 at 128 up.
// - Error counter bit 15 high while receive count is 128 or more.
// - Bits 14 to 8 show receive count; invalid once receive level is 11.
// - Bits 7 to 0 show transmit count; invalid while bus-off.
// - Both counters move per CAN fault confinement on errors and good frames.
// - Six enables read at 5..0; write bits 13..8 set, bits 5..0 clear.
// - Set only sets, clear only clears, both or neither leave the bit alone.
// - Each enable gates the pending interrupt of the same index to the output.
package cerr_pkg;
   localparam int ADDR_W = 20;
   localparam int IDX_W  = 18;
   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_LEC    = 18'h0ff92;
   localparam logic [IDX_W-1:0] IDX_INFO   = 18'h0ff93;
   localparam logic [IDX_W-1:0] IDX_ERC    = 18'h0ff94;
   localparam logic [IDX_W-1:0] IDX_IE     = 18'h0ff96;
   localparam logic [IDX_W-1:0] IDX_ISTAT  = 18'h0ffa0;
   localparam logic [IDX_W-1:0] IDX_ICLR   = 18'h0ffa1;
   localparam logic [IDX_W-1:0] IDX_IEN    = 18'h0ffa2;
   // Interrupt enable field positions
   localparam int IE_N      = 6;
   localparam int IE_SET_LO = 8;
   localparam int IE_CLR_LO = 0;
   // Error counter register field positions
   localparam int ERC_RX_PASSIVE_FLAG  = 15;
   localparam int ERC_REC_LO = 8;
   // Own event interrupt bits
   localparam int EV_N       = 3;
   localparam int EV_PROTO   = 0;
   localparam int EV_LEVEL   = 1;
   localparam int EV_BUSOFF  = 2;
   // Fault confinement figures
   localparam int TEC_W      = 9;
   localparam int REC_W      = 8;
   localparam int WARN_LVL   = 96;
   localparam int PASS_LVL   = 128;
   localparam int BUS_OFF_FLAG_LVL   = 256;
   localparam int REC_MAX    = 255;
   localparam int ERR_STEP   = 8;
   localparam int REC_RECOV  = 120;
   // Level field encodings
   localparam logic [1:0] LVL_LOW  = 2'h0;
   localparam logic [1:0] LVL_WARN = 2'h1;
   localparam logic [1:0] LVL_PASS = 2'h3;
   // Reset values
   localparam logic [2:0]  RST_LEC = 3'h0;
   localparam logic [IE_N-1:0] RST_IE = 6'h00;
   typedef enum logic [2:0] {
      CERR_LEC_NONE  = 3'b000,
      CERR_LEC_STUFF = 3'b001,
      CERR_LEC_FORM  = 3'b010,
      CERR_LEC_ACK   = 3'b011,
      CERR_LEC_BIT1  = 3'b100,
      CERR_LEC_BIT0  = 3'b101,
      CERR_LEC_CRC   = 3'b110,
      CERR_LEC_UNDEF = 3'b111
   } cerr_lec_t;
endpackage : cerr_pkg

// ---- logic/cerr_level.sv ----
// Error counter to warning and passive level encoder
`timescale 1ns/1ps
`default_nettype none
module cerr_level #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] count,
   output logic      [1:0]   level
);
   import cerr_pkg::*;
   localparam logic [W-1:0] WARN = W'(WARN_LVL);
   localparam logic [W-1:0] PASS = W'(PASS_LVL);
   // Code 10 is never produced
   always_comb begin
      if (count >= PASS)
         level = LVL_PASS;
      else if (count >= WARN)
         level = LVL_WARN;
      else
         level = LVL_LOW;
   end
endmodule : cerr_level
`default_nettype wire

// ---- logic/cerr_top.sv ----
// CAN error status, error counters and interrupt enable block with APB slave
`timescale 1ns/1ps
`default_nettype none
module cerr_top (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [cerr_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        mode_init,
   input  wire logic                        err_stuff,
   input  wire logic                        err_form,
   input  wire logic                        err_ack,
   input  wire logic                        err_crc,
   input  wire logic                        bit_chk,
   input  wire logic                        bit_sent,
   input  wire logic                        bit_bus,
   input  wire logic                        in_arb,
   input  wire logic                        tx_err_inc,
   input  wire logic                        tx_ok,
   input  wire logic                        rx_err_inc1,
   input  wire logic                        rx_err_inc8,
   input  wire logic                        rx_ok,
   input  wire logic                        ctr_clear,
   input  wire logic [cerr_pkg::IE_N-1:0]   irq_pending_bits,
   output logic      [cerr_pkg::IE_N-1:0]   irq_req,
   output logic                             bus_off_flag,
   output logic      [1:0]                  tx_error_level,
   output logic      [1:0]                  rx_error_level,
   output logic      [2:0]                  latest_fault_code,
   output logic                             irq
);
   import cerr_pkg::*;

   // APB decode
   logic [IDX_W-1:0] idx;
   logic             setup;
   logic             wr;
   logic             mapped;
   logic [31:0]      rd_val;
   logic [31:0]      next_prdata;
   logic             next_pslverr;

   // Block state
   logic [TEC_W-1:0] tec;
   logic [REC_W-1:0] rec;
   logic [TEC_W-1:0] next_tec;
   logic [REC_W-1:0] next_rec;
   logic [1:0]       next_tx_lvl;
   logic [1:0]       next_rx_lvl;
   logic [2:0]       next_lec;
   logic             err_hit;
   logic [2:0]       err_code;
   logic [IE_N-1:0]  irq_enable_bits;
   logic [IE_N-1:0]  next_ie;
   logic [IE_N-1:0]  ie_set;
   logic [IE_N-1:0]  ie_clr;
   logic [EV_N-1:0]  ev_stat;
   logic [EV_N-1:0]  ev_en;
   logic [EV_N-1:0]  next_ev_stat;
   logic [EV_N-1:0]  next_ev_en;
   logic [EV_N-1:0]  ev_set;
   logic             next_irq;

   assign idx   = paddr[ADDR_W-1:2];
   assign setup = psel && !penable;
   // Zero wait states: pready is high from the first edge after reset
   assign wr    = psel && penable && pready && pwrite && !pslverr;

   // Read mux and address check
   always_comb begin
      rd_val = 32'h0000_0000;
      mapped = (paddr[1:0] == 2'h0);
      unique case (idx)
         IDX_LEC:   rd_val[2:0] = latest_fault_code;
         IDX_INFO:  rd_val[4:0] = {bus_off_flag, tx_error_level, rx_error_level};
         IDX_ERC: begin
            rd_val[ERC_RX_PASSIVE_FLAG] = rec[REC_W-1];
            rd_val[ERC_RX_PASSIVE_FLAG-1:ERC_REC_LO] = rec[REC_W-2:0];
            rd_val[ERC_REC_LO-1:0] = tec[TEC_W-2:0];
         end
         IDX_IE:    rd_val[IE_N-1:0] = irq_enable_bits;
         IDX_ISTAT: rd_val[EV_N-1:0] = ev_stat;
         IDX_ICLR:  rd_val = 32'h0000_0000;
         IDX_IEN:   rd_val[EV_N-1:0] = ev_en;
         default:   mapped = 1'b0;
      endcase
   end

   // Read data and error are captured in the setup phase
   always_comb begin
      next_prdata  = prdata;
      next_pslverr = pslverr;
      if (setup) begin
         next_prdata  = (mapped && !pwrite) ? rd_val : 32'h0000_0000;
         next_pslverr = !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
         pready  <= 1'b1;
      end
   end

   // Protocol error classification; one error is reported per cycle
   always_comb begin
      err_hit  = 1'b1;
      err_code = CERR_LEC_NONE;
      if (bit_chk && bit_sent && !bit_bus && !in_arb)
         err_code = CERR_LEC_BIT1;
      else if (bit_chk && !bit_sent && bit_bus)
         err_code = CERR_LEC_BIT0;
      else if (err_stuff)
         err_code = CERR_LEC_STUFF;
      else if (err_form)
         err_code = CERR_LEC_FORM;
      else if (err_ack)
         err_code = CERR_LEC_ACK;
      else if (err_crc)
         err_code = CERR_LEC_CRC;
      else
         err_hit = 1'b0;
   end

   // A fresh error wins over a software clear in the same cycle
   always_comb begin
      next_lec = latest_fault_code;
      if (err_hit)
         next_lec = err_code;
      else if (wr && idx == IDX_LEC && pwdata[7:0] == 8'h00)
         next_lec = CERR_LEC_NONE;
      // Entering initialization mode leaves the code as it is
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         latest_fault_code <= RST_LEC;
      else
         latest_fault_code <= next_lec;
   end

   // Fault confinement counters; counting stops while bus-off
   always_comb begin
      next_tec = tec;
      next_rec = rec;
      if (ctr_clear) begin
         next_tec = '0;
         next_rec = '0;
      end else if (!tec[TEC_W-1]) begin
         if (tx_err_inc) begin
            if ({1'b0, tec} + 10'(ERR_STEP) >= 10'(BUS_OFF_FLAG_LVL))
               next_tec = TEC_W'(BUS_OFF_FLAG_LVL);
            else
               next_tec = tec + TEC_W'(ERR_STEP);
         end else if (tx_ok && tec != '0) begin
            next_tec = tec - TEC_W'(1);
         end
         if (rx_err_inc8 || rx_err_inc1) begin
            if ({1'b0, rec} + (rx_err_inc8 ? 9'(ERR_STEP) : 9'h001) > 9'(REC_MAX))
               next_rec = REC_W'(REC_MAX);
            else
               next_rec = rec + (rx_err_inc8 ? REC_W'(ERR_STEP) : REC_W'(1));
         end else if (rx_ok) begin
            if (rec >= REC_W'(PASS_LVL))
               next_rec = REC_W'(REC_RECOV);
            else if (rec != '0)
               next_rec = rec - REC_W'(1);
         end
      end
   end

   cerr_level #(.W(TEC_W)) u_tx_level (
      .count (next_tec),
      .level (next_tx_lvl)
   );

   cerr_level #(.W(REC_W)) u_rx_level (
      .count (next_rec),
      .level (next_rx_lvl)
   );

   // Summary flags are registered alongside the counts so reads agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tec            <= '0;
         rec            <= '0;
         bus_off_flag   <= 1'b0;
         tx_error_level <= LVL_LOW;
         rx_error_level <= LVL_LOW;
      end else begin
         tec            <= next_tec;
         rec            <= next_rec;
         bus_off_flag   <= next_tec[TEC_W-1];
         tx_error_level <= next_tx_lvl;
         rx_error_level <= next_rx_lvl;
      end
   end

   // Interrupt enables: set and clear halves of one write
   assign ie_set = pwdata[IE_SET_LO+IE_N-1:IE_SET_LO];
   assign ie_clr = pwdata[IE_CLR_LO+IE_N-1:IE_CLR_LO];

   always_comb begin
      next_ie = irq_enable_bits;
      if (wr && idx == IDX_IE)
         next_ie = (irq_enable_bits | (ie_set & ~ie_clr)) & ~(ie_clr & ~ie_set);
   end

   // Own events: sticky status, enable mask, write-one clear
   always_comb begin
      ev_set = '0;
      ev_set[EV_PROTO]  = err_hit;
      ev_set[EV_LEVEL]  = (next_tx_lvl != tx_error_level) || (next_rx_lvl != rx_error_level);
      ev_set[EV_BUSOFF] = next_tec[TEC_W-1] && !bus_off_flag;
      next_ev_stat = ev_stat;
      next_ev_en   = ev_en;
      if (wr && idx == IDX_ICLR)
         next_ev_stat = ev_stat & ~pwdata[EV_N-1:0];
      if (wr && idx == IDX_IEN)
         next_ev_en = pwdata[EV_N-1:0];
      next_ev_stat = next_ev_stat | ev_set;
      next_irq = |(next_ev_stat & next_ev_en);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable_bits <= RST_IE;
         irq_req         <= '0;
         ev_stat         <= '0;
         ev_en           <= '0;
         irq             <= 1'b0;
      end else begin
         irq_enable_bits <= next_ie;
         irq_req         <= irq_pending_bits & irq_enable_bits;
         ev_stat         <= next_ev_stat;
         ev_en           <= next_ev_en;
         irq             <= next_irq;
      end
   end

   // Checks
   AST_LEC_NONZERO_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == IDX_LEC && pwdata[7:0] != 8'h00 && !err_hit
      |=> latest_fault_code == $past(latest_fault_code))
      else $error("Nonzero write changed the last error code");

   AST_LEC_ZERO_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == IDX_LEC && pwdata[7:0] == 8'h00 && !err_hit
      |=> latest_fault_code == 3'h0)
      else $error("Zero write did not clear the last error code");

   AST_LEC_INIT_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(mode_init) && !err_hit && !(wr && idx == IDX_LEC)
      |=> $stable(latest_fault_code))
      else $error("Entering init mode altered the last error code");

   AST_LEC_BIT_REC: assert property (@(posedge pclk) disable iff (!presetn)
      bit_chk && bit_sent && !bit_bus && !in_arb |=> latest_fault_code == 3'h4)
      else $error("Recessive bit error not recorded as code 4");

   AST_LEC_BIT_DOM: assert property (@(posedge pclk) disable iff (!presetn)
      bit_chk && !bit_sent && bit_bus |=> latest_fault_code == 3'h5)
      else $error("Dominant bit error not recorded as code 5");

   AST_LEC_CRC: assert property (@(posedge pclk) disable iff (!presetn)
      err_crc && !bit_chk && !err_stuff && !err_form && !err_ack
      |=> latest_fault_code == 3'h6)
      else $error("CRC error not recorded as code 6");

   AST_BUS_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      bus_off_flag == (tec >= 9'h100))
      else $error("Bus-off flag disagrees with transmit count");

   AST_TX_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
      tx_error_level == ((tec >= 9'h080) ? 2'h3 : (tec >= 9'h060) ? 2'h1 : 2'h0))
      else $error("Transmit level field wrong");

   AST_RX_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
      rx_error_level == ((rec >= 8'h80) ? 2'h3 : (rec >= 8'h60) ? 2'h1 : 2'h0))
      else $error("Receive level field wrong");

   AST_ERC_READ: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr[1:0] == 2'h0 && idx == IDX_ERC
      |=> prdata[15:0] == {$past(rec >= 8'h80), $past(rec[6:0]), $past(tec[7:0])})
      else $error("Error counter read layout wrong");

   AST_TEC_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      tx_err_inc && !ctr_clear && tec < 9'h0f8 |=> tec == $past(tec) + 9'h008)
      else $error("Transmit count did not rise by eight");

   AST_REC_RECOVER: assert property (@(posedge pclk) disable iff (!presetn)
      rx_ok && !rx_err_inc1 && !rx_err_inc8 && !ctr_clear && !bus_off_flag
      && rec >= 8'h80 |=> rec == 8'h78)
      else $error("Receive count did not recover to 120");

   AST_IE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == IDX_IE |=> irq_enable_bits ==
      (($past(irq_enable_bits) | ($past(pwdata[13:8]) & ~$past(pwdata[5:0])))
       & ~($past(pwdata[5:0]) & ~$past(pwdata[13:8]))))
      else $error("Enable set or clear handled wrongly");

   AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 irq_req == $past(irq_pending_bits & irq_enable_bits))
      else $error("Interrupt request not gated by its enable");

endmodule : cerr_top
`default_nettype wire

// ---- bench/cerr_engine_model.sv ----
// Protocol engine and bus neighbour model that raises error events on command
`timescale 1ns/1ps
`default_nettype none
module cerr_engine_model (
   input  wire logic       pclk,
   input  wire logic [2:0] code,
   output logic            err_stuff,
   output logic            err_form,
   output logic            err_ack,
   output logic            err_crc,
   output logic            bit_chk,
   output logic            bit_sent,
   output logic            bit_bus,
   output logic            in_arb
);
   logic tog = 1'b0;
   always_ff @(posedge pclk) begin
      tog <= ~tog;
   end
   // Monitor lines toggle while unsampled so a stale level never looks valid
   // Command 7 is a recessive bit overridden inside arbitration: lost arbitration, no error
   always_comb begin
      err_stuff = (code == 3'h1);
      err_form  = (code == 3'h2);
      err_ack   = (code == 3'h3);
      err_crc   = (code == 3'h6);
      bit_chk   = (code == 3'h4) || (code == 3'h5) || (code == 3'h7);
      in_arb    = (code == 3'h7) ? 1'b1 : bit_chk ? 1'b0 : tog;
      bit_sent  = (code == 3'h4 || code == 3'h7) ? 1'b1 : (code == 3'h5) ? 1'b0 : tog;
      bit_bus   = (code == 3'h4 || code == 3'h7) ? 1'b0 : (code == 3'h5) ? 1'b1 : ~tog;
   end
endmodule : cerr_engine_model
`default_nettype wire

// ---- bench/cerr_top_bench.sv ----
// Self-checking bench for the CAN error status and interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module cerr_top_bench;
   import cerr_pkg::*;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0;
   logic [31:0]       prdata, rd;
   logic              pready, pslverr, er;
   logic              mode_init = 1'b0;
   logic [2:0]        code = 3'h0;
   logic [5:0]        ev = 6'h00;
   logic [IE_N-1:0]   pend = '0;
   logic              e_stuff, e_form, e_ack, e_crc, b_chk, b_sent, b_bus, arb;
   logic [IE_N-1:0]   irq_req;
   logic              bus_off_flag, irq;
   logic [1:0]        tx_error_level, rx_error_level;
   logic [2:0]        latest_fault_code;
   int                failures = 0;
   int                num_checks = 0;

   always #4 pclk = ~pclk;

   cerr_engine_model eng_u (.pclk(pclk), .code(code), .err_stuff(e_stuff), .err_form(e_form),
      .err_ack(e_ack), .err_crc(e_crc), .bit_chk(b_chk), .bit_sent(b_sent), .bit_bus(b_bus),
      .in_arb(arb));
   cerr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mode_init(mode_init), .err_stuff(e_stuff), .err_form(e_form),
      .err_ack(e_ack), .err_crc(e_crc), .bit_chk(b_chk), .bit_sent(b_sent), .bit_bus(b_bus),
      .in_arb(arb), .tx_err_inc(ev[0]), .tx_ok(ev[1]), .rx_err_inc1(ev[2]),
      .rx_err_inc8(ev[3]), .rx_ok(ev[4]), .ctr_clear(ev[5]), .irq_pending_bits(pend),
      .irq_req(irq_req), .bus_off_flag(bus_off_flag), .tx_error_level(tx_error_level),
      .rx_error_level(rx_error_level), .latest_fault_code(latest_fault_code), .irq(irq));

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : wt

   // Holds the request until pready is sampled high; the bound stops a hang
   task automatic apb(input logic w, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         failures++;
         report_and_stop();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic evs(input logic [5:0] v, input int n);
      repeat (n) begin
         @(posedge pclk);
         ev <= v;
      end
      @(posedge pclk);
      ev <= 6'h00;
   endtask : evs

   task automatic inject(input logic [2:0] c);
      @(posedge pclk);
      code <= c;
      @(posedge pclk);
      code <= 3'h0;
   endtask : inject

   task automatic t_reset;
      apb(1'b0, IDX_INFO, 32'h0);
      chk("summary", rd, 32'h0);
      apb(1'b0, IDX_ERC, 32'h0);
      chk("counters", rd, 32'h0);
      apb(1'b0, IDX_IE, 32'h0);
      chk("enables", rd, 32'h0);
      apb(1'b0, IDX_LEC, 32'h0);
      chk("fault reg", rd, 32'h0);
      apb(1'b0, 18'h0ff95, 32'h0);
      chk("unmapped", 32'(er), 32'h1);
      apb(1'b1, IDX_INFO, 32'hff);
      apb(1'b0, IDX_INFO, 32'h0);
      chk("summary ro", rd, 32'h0);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_lec;
      logic [2:0] cs [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
      foreach (cs[i]) begin
         inject(cs[i]);
         wt(1);
         chk("fault code", 32'(latest_fault_code), 32'(cs[i]));
         apb(1'b0, IDX_LEC, 32'h0);
         chk("fault reg", rd, 32'(cs[i]));
      end
      // A recessive bit overridden during arbitration is no error
      inject(3'h7);
      wt(1);
      chk("arb loss", 32'(latest_fault_code), 32'h6);
      apb(1'b1, IDX_LEC, 32'h5);
      apb(1'b0, IDX_LEC, 32'h0);
      chk("fault keep", rd, 32'h6);
      @(posedge pclk);
      mode_init <= 1'b1;
      wt(3);
      chk("fault init", 32'(latest_fault_code), 32'h6);
      apb(1'b1, IDX_LEC, 32'h0);
      apb(1'b0, IDX_LEC, 32'h0);
      chk("fault clear", rd, 32'h0);
      mode_init <= 1'b0;
      $display("t_lec done");
   endtask : t_lec

   task automatic t_ie;
      logic [15:0] wv [4] = '{16'h3f00, 16'h0101, 16'h0015, 16'h0501};
      logic [5:0]  ex [4] = '{6'h3f, 6'h3f, 6'h2a, 6'h2e};
      foreach (wv[i]) begin
         apb(1'b1, IDX_IE, {16'h0, wv[i]});
         apb(1'b0, IDX_IE, 32'h0);
         chk("enables", rd, 32'(ex[i]));
      end
      @(posedge pclk);
      pend <= 6'h15;
      wt(3);
      chk("irq gate", 32'(irq_req), 32'h04);
      @(posedge pclk);
      pend <= 6'h00;
      $display("t_ie done");
   endtask : t_ie

   task automatic chk_cnt(input int tec, input int rec);
      logic [1:0] tl, rl;
      logic bo;
      tl = (tec >= 128) ? LVL_PASS : (tec >= 96) ? LVL_WARN : LVL_LOW;
      rl = (rec >= 128) ? LVL_PASS : (rec >= 96) ? LVL_WARN : LVL_LOW;
      bo = (tec >= 256);
      wt(2);
      chk("bus off", 32'(bus_off_flag), 32'(bo));
      chk("tx level", 32'(tx_error_level), 32'(tl));
      chk("rx level", 32'(rx_error_level), 32'(rl));
      apb(1'b0, IDX_INFO, 32'h0);
      chk("summary", rd, {27'h0, bo, tl, rl});
      apb(1'b0, IDX_ERC, 32'h0);
      chk("rx passive", 32'(rd[15]), 32'(rec >= 128));
      if (rec < 128)
         chk("rx count", 32'(rd[14:8]), 32'(rec[6:0]));
      if (!bo)
         chk("tx count", 32'(rd[7:0]), 32'(tec[7:0]));
   endtask : chk_cnt

   task automatic t_cnt;
      evs(6'h01, 12);
      chk_cnt(96, 0);
      evs(6'h01, 4);
      chk_cnt(128, 0);
      evs(6'h02, 1);
      chk_cnt(127, 0);
      evs(6'h08, 11);
      evs(6'h04, 8);
      chk_cnt(127, 96);
      evs(6'h04, 31);
      chk_cnt(127, 127);
      evs(6'h04, 1);
      chk_cnt(127, 128);
      evs(6'h10, 1);
      chk_cnt(127, REC_RECOV);
      evs(6'h01, 16);
      chk_cnt(255, REC_RECOV);
      evs(6'h01, 1);
      chk_cnt(256, REC_RECOV);
      evs(6'h02, 2);
      chk_cnt(256, REC_RECOV);
      evs(6'h20, 1);
      chk_cnt(0, 0);
      evs(6'h04, 2);
      evs(6'h10, 1);
      chk_cnt(0, 1);
      $display("t_cnt done");
   endtask : t_cnt

   task automatic t_irq;
      apb(1'b1, IDX_ICLR, 32'h7);
      apb(1'b1, IDX_IEN, 32'h1);
      inject(CERR_LEC_FORM);
      wt(3);
      chk("irq raised", 32'(irq), 32'h1);
      apb(1'b1, IDX_ICLR, 32'h1);
      wt(2);
      chk("irq cleared", 32'(irq), 32'h0);
      apb(1'b1, IDX_IEN, 32'h0);
      inject(CERR_LEC_ACK);
      wt(3);
      chk("irq masked", 32'(irq), 32'h0);
      apb(1'b0, IDX_ISTAT, 32'h0);
      chk("status sticky", 32'(rd[0]), 32'h1);
      $display("t_irq done");
   endtask : t_irq

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      wt(2);
      t_reset();
      t_lec();
      t_ie();
      t_cnt();
      t_irq();
      report_and_stop();
   end
endmodule : cerr_top_bench
`default_nettype wire
